// ---- fan_cfg_pkg.sv ----
/*
 * shared constants, types and helpers for the fan monitor configuration block.
 * assumes a single 250 MHz clock domain and 8-bit registers in the low byte lane.
 */
package fan_cfg_pkg;

    // ****************************************
    // register map (index; byte address is four times it)
    // ****************************************
    localparam int          ADDR_W          = 10;
    localparam logic [7:0]  CFG_IDX         = 8'h7D;
    localparam logic [7:0]  TEST_ONE_IDX    = 8'h7E;
    localparam logic [7:0]  TEST_TWO_IDX    = 8'h7F;
    localparam logic [7:0]  CFG_RESET       = 8'h00;
    localparam logic [7:0]  TEST_ONE_RESET  = 8'h00;
    localparam logic [7:0]  TEST_TWO_RESET  = 8'h00;

    // ****************************************
    // configuration fields
    // ****************************************
    localparam int          FUNC_LSB        = 0;
    localparam int          FUNC_MSB        = 1;
    localparam int          OT_DISABLE_BIT  = 2;
    localparam int          OT_SPEED_BIT    = 3;
    localparam int          BYPASS_BIT      = 5;
    localparam logic [7:0]  CFG_WRITE_MASK  = 8'h2F;

    // ****************************************
    // limits and scales
    // ****************************************
    localparam int          NUM_CHAN        = 3;
    localparam int          NUM_FAN         = 3;
    localparam logic [7:0]  OFF64_LIMIT_OFF = 8'h00;
    localparam logic [7:0]  TWOS_LIMIT_OFF  = 8'h80;
    localparam logic [7:0]  FAN_FULL_DUTY   = 8'hFF;
    localparam int          CORE_FULL_SCALE_UV = 2296500;

    typedef enum logic [1:0] {
        PIN_FAN_TACH  = 2'h0,
        PIN_OVERTEMP  = 2'h1,
        PIN_BUS_ALERT = 2'h2,
        PIN_GPIO      = 2'h3
    } pin_func_e;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } bus_state_e;

    typedef struct packed {
        logic [7:0] limit;
        logic       enable;
        logic       exceeded;
    } chan_s;

    typedef struct packed {
        logic dir;
        logic level;
    } gpio_ctl_s;

    // limit code that switches a channel's over-temperature off
    function automatic logic limit_off(input logic [7:0] limit, input logic twos);
        limit_off = twos ? (limit == TWOS_LIMIT_OFF) : (limit == OFF64_LIMIT_OFF);
    endfunction

    function automatic logic chan_live(input chan_s c, input logic twos);
        chan_live = c.enable & c.exceeded & ~limit_off(c.limit, twos);
    endfunction

endpackage

// ---- shared_pin_router.sv ----
/*
 * routes the shared multi-purpose pin by the function select code.
 * assumes the pin is open drain for over-temperature and alert; all inputs synchronous.
 */
`timescale 1ns/100ps
module shared_pin_router (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire fan_cfg_pkg::pin_func_e func,
    input  wire logic                  overtemp_assert,
    input  wire logic                  alert_request,
    input  wire fan_cfg_pkg::gpio_ctl_s gpio_ctl,
    input  wire logic                  pin_in,
    output logic                       pin_out,
    output logic                       pin_oe,
    output logic                       fan_four_tach_input,
    output logic                       overtemp_sensed,
    output logic                       gpio_in
);
    logic next_pin_out;
    logic next_pin_oe;
    logic next_tach;
    logic next_sensed;
    logic next_gpio_in;

    // ****************************************
    // routing
    // ****************************************
    always_comb begin
        next_pin_out = 1'b0;
        next_pin_oe  = 1'b0;
        next_tach    = 1'b0;
        next_sensed  = 1'b0;
        next_gpio_in = 1'b0;
        unique case (func)
            fan_cfg_pkg::PIN_FAN_TACH: begin
                next_tach = pin_in;
            end
            fan_cfg_pkg::PIN_OVERTEMP: begin
                // pulled low while asserted; the far end may also pull it
                next_pin_oe = overtemp_assert;
                next_sensed = ~pin_in;
            end
            fan_cfg_pkg::PIN_BUS_ALERT: begin
                next_pin_oe = alert_request;
            end
            fan_cfg_pkg::PIN_GPIO: begin
                next_pin_out = gpio_ctl.level;
                next_pin_oe  = gpio_ctl.dir;
                next_gpio_in = pin_in;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_out             <= 1'b0;
            pin_oe              <= 1'b0;
            fan_four_tach_input <= 1'b0;
            overtemp_sensed     <= 1'b0;
            gpio_in             <= 1'b0;
        end else begin
            pin_out             <= next_pin_out;
            pin_oe              <= next_pin_oe;
            fan_four_tach_input <= next_tach;
            overtemp_sensed     <= next_sensed;
            gpio_in             <= next_gpio_in;
        end
    end

endmodule // shared_pin_router

// ---- overtemp_fan_override.sv ----
/*
 * qualifies over-temperature trips per channel and overrides fan duty.
 * assumes limit comparison flags and the loop duties arrive synchronous to clk.
 */
`timescale 1ns/100ps
module overtemp_fan_override (
    input  wire logic                                   clk,
    input  wire logic                                   rst_n,
    input  wire fan_cfg_pkg::chan_s [fan_cfg_pkg::NUM_CHAN-1:0] chan,
    input  wire logic                                   twos_mode,
    input  wire logic                                   output_disable,
    input  wire logic                                   pin_is_overtemp,
    input  wire logic                                   speed_select,
    input  wire logic [fan_cfg_pkg::NUM_FAN-1:0][7:0]   fan_max_duty,
    input  wire logic [fan_cfg_pkg::NUM_FAN-1:0][7:0]   fan_loop_duty,
    output logic                                        overtemp_assert,
    output logic [fan_cfg_pkg::NUM_FAN-1:0][7:0]        fan_duty
);
    logic                                      trip;
    logic                                      next_assert;
    logic [fan_cfg_pkg::NUM_FAN-1:0][7:0]      next_duty;

    always_comb begin
        trip = 1'b0;
        for (int i = 0; i < fan_cfg_pkg::NUM_CHAN; i++) begin
            trip = trip | fan_cfg_pkg::chan_live(chan[i], twos_mode);
        end
        next_assert = trip & ~output_disable & pin_is_overtemp;
        next_duty   = fan_loop_duty;
        if (trip) begin
            for (int f = 0; f < fan_cfg_pkg::NUM_FAN; f++) begin
                next_duty[f] = speed_select ? fan_max_duty[f] : fan_cfg_pkg::FAN_FULL_DUTY;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            overtemp_assert <= 1'b0;
            fan_duty        <= '0;
        end else begin
            overtemp_assert <= next_assert;
            fan_duty        <= next_duty;
        end
    end

endmodule // overtemp_fan_override

// ---- fan_monitor_config_register.sv ----
/*
 * configuration register bank with Avalon-MM slave, shared pin routing and
 * over-temperature fan override.
 * assumes a master that holds its request until waitrequest is low, and a
 * lock level from the global configuration register.
 */
`timescale 1ns/100ps
module fan_monitor_config_register (
    input  wire logic                                          clk,
    input  wire logic                                          rstn,
    input  wire logic [fan_cfg_pkg::ADDR_W-1:0]                address,
    input  wire logic                                          read,
    input  wire logic                                          write,
    input  wire logic [31:0]                                   writedata,
    input  wire logic [3:0]                                    byteenable,
    output logic [31:0]                                        readdata,
    output logic                                               waitrequest,
    input  wire logic                                          config_lock,
    input  wire logic                                          twos_mode,
    input  wire fan_cfg_pkg::chan_s [fan_cfg_pkg::NUM_CHAN-1:0] chan,
    input  wire logic [fan_cfg_pkg::NUM_FAN-1:0][7:0]          fan_max_duty,
    input  wire logic [fan_cfg_pkg::NUM_FAN-1:0][7:0]          fan_loop_duty,
    input  wire logic                                          alert_request,
    input  wire fan_cfg_pkg::gpio_ctl_s                        gpio_ctl,
    input  wire logic                                          pin_in,
    output logic                                               pin_out,
    output logic                                               pin_oe,
    output logic                                               fan_four_tach_input,
    output logic                                               overtemp_sensed,
    output logic                                               gpio_in,
    output logic                                               overtemp_active,
    output logic [fan_cfg_pkg::NUM_FAN-1:0][7:0]               fan_duty,
    output logic                                               core_voltage_attenuator_bypass
);

    // ****************************************
    // reset release
    // ****************************************
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ****************************************
    // bus slave
    // ****************************************
    fan_cfg_pkg::bus_state_e state;
    fan_cfg_pkg::bus_state_e next_state;
    logic                    next_waitrequest;
    logic [31:0]             next_readdata;
    logic [7:0]              cfg;
    logic [7:0]              next_cfg;
    logic [7:0]              reg_idx;
    logic                    word_ok;
    logic                    cfg_write;

    assign reg_idx = address[fan_cfg_pkg::ADDR_W-1:2];
    assign word_ok = (address[1:0] == 2'h0);

    always_comb begin
        next_state       = state;
        next_waitrequest = waitrequest;
        next_readdata    = readdata;
        unique case (state)
            fan_cfg_pkg::BUS_IDLE: begin
                if (read || write) begin
                    next_state       = fan_cfg_pkg::BUS_ACK;
                    next_waitrequest = 1'b0;
                    next_readdata    = 32'h0000_0000;
                    if (read && word_ok) begin
                        unique case (reg_idx)
                            fan_cfg_pkg::CFG_IDX:      next_readdata = {24'h00_0000, cfg};
                            fan_cfg_pkg::TEST_ONE_IDX: next_readdata = {24'h00_0000, fan_cfg_pkg::TEST_ONE_RESET};
                            fan_cfg_pkg::TEST_TWO_IDX: next_readdata = {24'h00_0000, fan_cfg_pkg::TEST_TWO_RESET};
                            default:                   next_readdata = 32'h0000_0000;
                        endcase
                    end
                end
            end
            fan_cfg_pkg::BUS_ACK: begin
                next_state       = fan_cfg_pkg::BUS_IDLE;
                next_waitrequest = 1'b1;
            end
            default: begin
                next_state       = fan_cfg_pkg::BUS_IDLE;
                next_waitrequest = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state       <= fan_cfg_pkg::BUS_IDLE;
            waitrequest <= 1'b1;
            readdata    <= 32'h0000_0000;
        end else begin
            state       <= next_state;
            waitrequest <= next_waitrequest;
            readdata    <= next_readdata;
        end
    end

    // ****************************************
    // configuration register
    // ****************************************
    // write lands on the edge where waitrequest is seen low; test registers have no storage
    assign cfg_write = (state == fan_cfg_pkg::BUS_ACK) && write && word_ok && byteenable[0]
                       && (reg_idx == fan_cfg_pkg::CFG_IDX);

    always_comb begin
        next_cfg = cfg;
        if (cfg_write && !config_lock) begin
            next_cfg = writedata[7:0] & fan_cfg_pkg::CFG_WRITE_MASK;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg <= fan_cfg_pkg::CFG_RESET;
        end else begin
            cfg <= next_cfg;
        end
    end

    // ****************************************
    // attenuator bypass
    // ****************************************
    // only the scale flag leaves here; the converter applies the full-scale value
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            core_voltage_attenuator_bypass <= 1'b0;
        end else begin
            core_voltage_attenuator_bypass <= cfg[fan_cfg_pkg::BYPASS_BIT];
        end
    end

    // ****************************************
    // submodules
    // ****************************************
    fan_cfg_pkg::pin_func_e func;

    assign func = fan_cfg_pkg::pin_func_e'(cfg[fan_cfg_pkg::FUNC_MSB:fan_cfg_pkg::FUNC_LSB]);

    overtemp_fan_override u_override (
        .clk             (clk),
        .rst_n           (rst_n),
        .chan            (chan),
        .twos_mode       (twos_mode),
        .output_disable  (cfg[fan_cfg_pkg::OT_DISABLE_BIT]),
        .pin_is_overtemp (func == fan_cfg_pkg::PIN_OVERTEMP),
        .speed_select    (cfg[fan_cfg_pkg::OT_SPEED_BIT]),
        .fan_max_duty    (fan_max_duty),
        .fan_loop_duty   (fan_loop_duty),
        .overtemp_assert (overtemp_active),
        .fan_duty        (fan_duty)
    );

    // pin sees the assert one cycle after the override flop, a small extra latency
    shared_pin_router u_router (
        .clk                 (clk),
        .rst_n               (rst_n),
        .func                (func),
        .overtemp_assert     (overtemp_active),
        .alert_request       (alert_request),
        .gpio_ctl            (gpio_ctl),
        .pin_in              (pin_in),
        .pin_out             (pin_out),
        .pin_oe              (pin_oe),
        .fan_four_tach_input (fan_four_tach_input),
        .overtemp_sensed     (overtemp_sensed),
        .gpio_in             (gpio_in)
    );

    // ****************************************
    // checks
    // ****************************************
    logic any_live;

    always_comb begin
        any_live = 1'b0;
        for (int i = 0; i < fan_cfg_pkg::NUM_CHAN; i++) begin
            any_live = any_live | fan_cfg_pkg::chan_live(chan[i], twos_mode);
        end
    end

    pin_tach_route_a: assert property (@(posedge clk) disable iff (!rst_n)
        (func == fan_cfg_pkg::PIN_FAN_TACH) |=> (fan_four_tach_input == $past(pin_in) && !pin_oe))
        else $error("tach route wrong");

    overtemp_disable_a: assert property (@(posedge clk) disable iff (!rst_n)
        cfg[fan_cfg_pkg::OT_DISABLE_BIT] |=> !overtemp_active)
        else $error("overtemp not suppressed");

    overtemp_cause_a: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 overtemp_active |-> $past(any_live && !cfg[fan_cfg_pkg::OT_DISABLE_BIT]
            && func == fan_cfg_pkg::PIN_OVERTEMP))
        else $error("overtemp without cause");

    off64_limit_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!twos_mode && chan[0].limit == 8'h00 && chan[1].limit == 8'h00 && chan[2].limit == 8'h00)
        |=> !overtemp_active)
        else $error("offset64 off limit ignored");

    twos_limit_a: assert property (@(posedge clk) disable iff (!rst_n)
        (twos_mode && chan[0].limit == 8'h80 && chan[1].limit == 8'h80 && chan[2].limit == 8'h80)
        |=> !overtemp_active)
        else $error("twos off limit ignored");

    full_speed_a: assert property (@(posedge clk) disable iff (!rst_n)
        (any_live && !cfg[fan_cfg_pkg::OT_SPEED_BIT]) |=> (fan_duty == {3{8'hFF}}))
        else $error("fans not at full speed");

    max_speed_a: assert property (@(posedge clk) disable iff (!rst_n)
        (any_live && cfg[fan_cfg_pkg::OT_SPEED_BIT]) |=> (fan_duty == $past(fan_max_duty)))
        else $error("fans not at max duty");

    bypass_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
        cfg_write && !config_lock |=> ##1 (core_voltage_attenuator_bypass == $past(writedata[5], 2)))
        else $error("bypass flag wrong");

    lock_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cfg_write && config_lock) |=> $stable(cfg))
        else $error("locked register changed");

    reset_clear_a: assert property (@(posedge clk)
        $rose(rst_n) |-> (cfg == 8'h00 && waitrequest))
        else $error("config not clear after reset");

    test_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state == fan_cfg_pkg::BUS_IDLE && read && word_ok && reg_idx >= 8'h7E && reg_idx <= 8'h7F)
        |=> (!waitrequest && readdata == 32'h0000_0000))
        else $error("test register not zero");

    unused_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        cfg_write |=> ((cfg & 8'hD0) == 8'h00))
        else $error("unused bits set");

    bus_ack_once_a: assert property (@(posedge clk) disable iff (!rst_n)
        !waitrequest |=> waitrequest)
        else $error("ack longer than one cycle");

    overtemp_pin_a: assert property (@(posedge clk) disable iff (!rst_n)
        (func == fan_cfg_pkg::PIN_OVERTEMP) |=> (pin_oe == $past(overtemp_active) && !pin_out))
        else $error("overtemp pin drive wrong");

    alert_route_a: assert property (@(posedge clk) disable iff (!rst_n)
        (func == fan_cfg_pkg::PIN_BUS_ALERT) |=> (pin_oe == $past(alert_request) && !pin_out))
        else $error("alert pin drive wrong");

    gpio_route_a: assert property (@(posedge clk) disable iff (!rst_n)
        (func == fan_cfg_pkg::PIN_GPIO) |=> (pin_out == $past(gpio_ctl.level) && pin_oe == $past(gpio_ctl.dir)))
        else $error("gpio pin drive wrong");

    overtemp_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
        (any_live && !cfg[fan_cfg_pkg::OT_DISABLE_BIT] && func == fan_cfg_pkg::PIN_OVERTEMP) |=> overtemp_active)
        else $error("permitted overtemp not driven");

    read_upper_a: assert property (@(posedge clk) disable iff (!rst_n)
        !waitrequest |-> (readdata[31:8] == 24'h00_0000))
        else $error("upper read bits set");

    cfg_write_c: cover property (@(posedge clk) disable iff (!rst_n) cfg_write && !config_lock);
    locked_write_c: cover property (@(posedge clk) disable iff (!rst_n) cfg_write && config_lock);
    overtemp_drive_c: cover property (@(posedge clk) disable iff (!rst_n) pin_oe && func == fan_cfg_pkg::PIN_OVERTEMP);
    max_override_c: cover property (@(posedge clk) disable iff (!rst_n) any_live && cfg[fan_cfg_pkg::OT_SPEED_BIT]);

endmodule // fan_monitor_config_register

// ---- pin_partner.sv ----
/*
 * far side of the shared pin: wire with a pull-up and one outside driver, which the design's drive overrides while pin_oe is high.
 * assumes nothing of pin_out while pin_oe is low; in gpio mode the design sets it from the level even then.
 */
`timescale 1ns/100ps
module pin_partner (
    input  wire logic ext_low,
    input  wire logic pin_out,
    input  wire logic pin_oe,
    output logic      pin_level
);
    // shared pin wire
    // pull-up wins when nobody drives, so an idle pin never reads stale data
    assign pin_level = pin_oe ? pin_out : ~ext_low;
endmodule // pin_partner

// ---- testbench.sv ----
/*
 * self-checking bench for the fan monitor configuration block.
 * assumes fan_cfg_pkg and pin_partner are compiled before it.
 */
`timescale 1ns/100ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; $display("BAD %s exp %h got %h", n, e, g); end end
module testbench;
    typedef struct packed { logic [7:0] w; logic [7:0] r; } row_s;
    logic                             clk = 0, rstn = 0, read = 0, write = 0;
    logic                             lock = 0, twos = 0, alert = 1, ext_low = 0;
    logic [9:0]                       address = '0;
    logic [31:0]                      writedata = '0, readdata;
    logic [3:0]                       byteenable = 4'hF;
    fan_cfg_pkg::chan_s [2:0]         chan = '0;
    logic [2:0][7:0]                  maxd = {8'h92, 8'h91, 8'h90}, loopd = {3{8'h40}}, duty;
    fan_cfg_pkg::gpio_ctl_s           gpio = '{1'b1, 1'b1};
    logic                             waitrequest, pin_level, pin_out, pin_oe, tach, sensed, gin, ot, bypass, lvl;
    logic [7:0]                       q;
    int                               error_cnt = 0, cmp_count = 0, cyc = 0;
    row_s                             rows [4] = '{'{8'hFF, 8'h2F}, '{8'hD0, 8'h00}, '{8'h2A, 8'h2A}, '{8'h10, 8'h00}};

    always #2 clk = ~clk;

    fan_monitor_config_register fan_monitor_config_register_i (.clk(clk), .rstn(rstn), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .config_lock(lock), .twos_mode(twos), .chan(chan), .fan_max_duty(maxd),
        .fan_loop_duty(loopd), .alert_request(alert), .gpio_ctl(gpio), .pin_in(pin_level), .pin_out(pin_out),
        .pin_oe(pin_oe), .fan_four_tach_input(tach), .overtemp_sensed(sensed), .gpio_in(gin),
        .overtemp_active(ot), .fan_duty(duty), .core_voltage_attenuator_bypass(bypass));

    pin_partner pin_partner_i (.ext_low(ext_low), .pin_out(pin_out), .pin_oe(pin_oe), .pin_level(pin_level));

    // ****************************************
    // tasks
    // ****************************************
    task finish_test;
        $display("comparisons %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // request held until waitrequest is seen low at a rising edge
    // no local limit: a hung slave is caught by the cycle ceiling below
    task bus(input logic wr, input logic [9:0] a, input logic [7:0] d);
        address <= a;
        writedata <= {24'h0, d};
        write <= wr;
        read <= ~wr;
        do begin
            @(posedge clk);
        end while (waitrequest !== 1'b0);
        q = readdata[7:0];
        write <= 1'b0;
        read <= 1'b0;
        @(posedge clk);
    endtask

    task settle;
        repeat (4) @(posedge clk);
    endtask

    task rd(input logic [9:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        `CHK("readdata", e, q)
    endtask

    // trip on channel 0, then check output, pin drive and fan duty
    task ot_case(input logic [7:0] cfg, lim, input logic en, tw, ea, input logic [7:0] d0);
        twos <= tw;
        // idle channels carry the same limit so the all-channels-off checks can fire
        chan <= '{'{lim, 1'b0, 1'b0}, '{lim, 1'b0, 1'b0}, '{lim, en, 1'b1}};
        bus(1'b1, 10'h1F4, cfg);
        settle();
        `CHK("overtemp_active", ea, ot)
        `CHK("pin_oe", ea, pin_oe)
        `CHK("fan_duty0", d0, duty[0])
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            finish_test();
        end
    end

    // ****************************************
    // sequence
    // ****************************************
    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        foreach (rows[i]) begin
            bus(1'b1, 10'h1F4, rows[i].w);
            settle();
            rd(10'h1F4, rows[i].r);
            `CHK("bypass", rows[i].r[5], bypass)
        end
        for (int p = 0; p < 2; p++) begin
            for (int f = 0; f < 4; f++) begin
                // second pass releases alert and gpio so the pull-up shows
                ext_low <= ~p[0];
                alert <= ~p[0];
                gpio <= '{~p[0], 1'b1};
                bus(1'b1, 10'h1F4, {6'h0, f[1:0]});
                settle();
                lvl = p[0] | (f == 3);
                `CHK("tach", (f == 0) & lvl, tach)
                `CHK("sensed", (f == 1) & ~lvl, sensed)
                `CHK("gpio_in", (f == 3) & lvl, gin)
                `CHK("pin_oe", (f >= 2) & ~p[0], pin_oe)
                `CHK("pin_out", f == 3, pin_out)
            end
        end
        ext_low <= 1'b0;
        ot_case(8'h01, 8'h50, 1'b1, 1'b0, 1'b1, 8'hFF);
        ot_case(8'h05, 8'h50, 1'b1, 1'b0, 1'b0, 8'hFF);
        ot_case(8'h09, 8'h50, 1'b1, 1'b0, 1'b1, 8'h90);
        `CHK("fan_duty2", 8'h92, duty[2])
        ot_case(8'h01, 8'h50, 1'b0, 1'b0, 1'b0, 8'h40);
        ot_case(8'h00, 8'h50, 1'b1, 1'b0, 1'b0, 8'hFF);
        ot_case(8'h01, 8'h00, 1'b1, 1'b0, 1'b0, 8'h40);
        ot_case(8'h01, 8'h80, 1'b1, 1'b0, 1'b1, 8'hFF);
        ot_case(8'h01, 8'h80, 1'b1, 1'b1, 1'b0, 8'h40);
        ot_case(8'h01, 8'h00, 1'b1, 1'b1, 1'b1, 8'hFF);
        // lock level blocks the write; low lane disabled also blocks it
        lock <= 1'b1;
        bus(1'b1, 10'h1F4, 8'h20);
        rd(10'h1F4, 8'h01);
        lock <= 1'b0;
        byteenable <= 4'h0;
        bus(1'b1, 10'h1F4, 8'h20);
        byteenable <= 4'hF;
        rd(10'h1F4, 8'h01);
        bus(1'b1, 10'h1F8, 8'hFF);
        rd(10'h1F8, 8'h00);
        bus(1'b1, 10'h1FC, 8'hA5);
        rd(10'h1FC, 8'h00);
        rd(10'h100, 8'h00);
        // second reset in mid-run clears the config; bypass and drive set first so the clear shows
        bus(1'b1, 10'h1F4, 8'h21);
        settle();
        `CHK("bypass", 1'b1, bypass)
        `CHK("overtemp_active", 1'b1, ot)
        rstn <= 1'b0;
        repeat (5) @(posedge clk);
        `CHK("waitrequest", 1'b1, waitrequest)
        `CHK("overtemp_active", 1'b0, ot)
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        rd(10'h1F4, 8'h00);
        `CHK("bypass", 1'b0, bypass)
        finish_test();
    end
endmodule // testbench
